// ---- logic/crc_pkg.sv ----
// Shared constants and carrier types for the chip reset combiner
package crc_pkg;

	// System clock rate
	localparam int CRC_CLOCK_HZ = 50_000_000;
	localparam int CRC_CYC_PER_MS = CRC_CLOCK_HZ / 1000;

	// Supply qualification times in milliseconds and their cycle counts
	localparam int CRC_BANDGAP_MS = 8;
	localparam int CRC_ANALOG_MS = 4;
	localparam int CRC_BANDGAP_CYC = CRC_BANDGAP_MS * CRC_CYC_PER_MS;
	localparam int CRC_ANALOG_CYC = CRC_ANALOG_MS * CRC_CYC_PER_MS;
	localparam int CRC_TMR_W = 20;

	// Reset pin must be seen low this many system clock periods
	localparam int CRC_PIN_LOW_MIN = 3;
	localparam logic [1:0] CRC_PIN_LOW_LAST = 2'(CRC_PIN_LOW_MIN - 1);
	localparam logic [1:0] CRC_PIN_CNT_RST = 2'h0;

	// Software reset fan-out and bus selection width
	localparam int CRC_PERIPH_N = 8;
	localparam int CRC_BUS_SEL_W = 16;
	localparam logic [CRC_BUS_SEL_W-1:0] CRC_BUS_SEL_RST = 16'h0000;
	localparam logic [CRC_PERIPH_N-1:0] CRC_PERIPH_RST = 8'h00;

	// Width of the pin synchroniser bank
	localparam int CRC_SYNC_W = 7;
	// Reset pin bit idles high so the low filter sees no false pulse after reset
	localparam logic [CRC_SYNC_W-1:0] CRC_SYNC_RST = 7'h40;

	// Supply status bits coming from the analog monitors
	typedef struct packed {
		logic reg_input_ok;
		logic bandgap_on;
		logic analog_on;
		logic output_above;
	} crc_supply_t;

	// Pin group control during and after reset
	typedef struct packed {
		logic forced;
		logic high_grp;
		logic low_grp;
		logic z_grp_oe;
		logic clock_output_pin_en;
		logic synch_grp;
	} crc_pin_ctl_t;

	localparam crc_pin_ctl_t CRC_PIN_CTL_RST = '{forced: 1'h1, high_grp: 1'h1, low_grp: 1'h0,
		z_grp_oe: 1'h0, clock_output_pin_en: 1'h1, synch_grp: 1'h0};

	// Boot sequencer states, Gray along hold, boot, run
	typedef enum logic [1:0] {
		CRC_ST_HOLD = 2'h0,
		CRC_ST_BOOT = 2'h1,
		CRC_ST_RUN = 2'h3
	} crc_state_t;

endpackage : crc_pkg

// ---- logic/crc_qual_timer.sv ----
// Qualifies a level as stable after a fixed number of consecutive cycles
`timescale 1ns/1ns
module crc_qual_timer #(
	parameter int CYCLES = 16
) (
	input wire logic clock, // System clock
	input wire logic rst_b, // Synchronous reset, active low
	input wire logic level, // Level to qualify
	output logic done // High once level held CYCLES cycles
);
	import crc_pkg::*;

	logic [CRC_TMR_W-1:0] count;
	wire logic reached = (count == CRC_TMR_W'(CYCLES - 1));

	always_ff @(posedge clock) begin
		if (!rst_b || !level) begin
			count <= '0;
			done <= 1'h0;
		end else if (!done) begin
			count <= reached ? count : count + CRC_TMR_W'(1);
			done <= reached;
		end
	end

endmodule : crc_qual_timer

// ---- logic/crc_reset_combiner.sv ----
// Reset combiner: power-ok generation, global reset, boot start, RTC power-on reset, pin groups
//
// Behaviour
// - Global reset (active low) is the AND of the filtered reset pin level, power-ok and the logic reset.
// - With the core regulator disabled, monitoring stops and power-ok goes high at once.
// - With the regulator enabled, power-ok stays low until input supply, 8 ms bandgap, 4 ms analog supply and output above 950 mV all hold.
// - Once power-ok is high the comparator threshold drops to about 850 mV for hysteresis.
// - Global reset clears the whole chip except the real-time-clock domain, which it leaves alone.
// - Release of the global reset starts the boot sequence.
// - The system clock generator is enabled while hardware reset is applied.
// - A separate RTC power-on reset resets the RTC registers when its core supply first appears.
// - The RTC power-on reset sets the power-loss flag telling software to set time and date.
// - During reset, output pins take their group states: high, low, high impedance, clock output, and 0 then 1.
// - Outside reset each multiplexed pin follows the peripheral chosen in the bus selection setting.
// - CPU and per-peripheral software resets exist apart from the hardware reset.
`timescale 1ns/1ns
module crc_reset_combiner #(
	parameter int BANDGAP_CYC = crc_pkg::CRC_BANDGAP_CYC, // Bandgap settle cycles
	parameter int ANALOG_CYC = crc_pkg::CRC_ANALOG_CYC // Analog supply settle cycles
) (
	input wire logic clock, // System clock, 50 MHz
	input wire logic rst_b, // Synchronous logic reset, active low
	input wire logic reset_pin_n, // External reset pin, active low
	input wire logic core_regulator_enable_n, // High disables the core regulator
	input wire crc_pkg::crc_supply_t supply, // Analog monitor status bits
	input wire logic rtc_core_supply, // RTC core supply present
	input wire logic rtc_time_written, // Software has set time, clears flag
	input wire logic clk_gen_off_req, // Software request to stop clock generator
	input wire logic cpu_reset_req, // CPU reset instruction
	input wire logic [crc_pkg::CRC_PERIPH_N-1:0] periph_reset_req, // Peripheral software resets
	input wire logic [crc_pkg::CRC_BUS_SEL_W-1:0] external_bus_select_reg, // Pin mux setting
	output logic global_reset_n, // Global hardware reset, active low
	output logic power_ok_signal, // Main power-on detector result
	output logic comparator_enable, // Output voltage monitor active
	output logic threshold_low, // Comparator uses the lower threshold
	output logic boot_start, // One-cycle pulse starting boot
	output logic clock_gen_enable, // System clock generator enable
	output logic cpu_reset_n, // CPU reset, active low
	output logic [crc_pkg::CRC_PERIPH_N-1:0] periph_reset_n, // Peripheral resets, active low
	output logic rtc_reg_reset_n, // RTC register reset, active low
	output logic rtc_power_loss_flag, // RTC lost power, time invalid
	output crc_pkg::crc_pin_ctl_t pin_ctl, // Pin group states
	output logic [crc_pkg::CRC_BUS_SEL_W-1:0] pin_mux_sel // Effective pin mux select
);
	import crc_pkg::*;

	// Pin synchroniser bank; stage one feeds stage two only
	logic [CRC_SYNC_W-1:0] sync_a;
	logic [CRC_SYNC_W-1:0] sync_b;
	wire logic [CRC_SYNC_W-1:0] raw_pins = {reset_pin_n, core_regulator_enable_n,
		supply, rtc_core_supply};

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			sync_a <= CRC_SYNC_RST;
			sync_b <= CRC_SYNC_RST;
		end else begin
			sync_a <= raw_pins;
			sync_b <= sync_a;
		end
	end

	wire logic pin_s = sync_b[6];
	wire logic reg_disabled = sync_b[5];
	wire crc_supply_t sup_s = sync_b[4:1];
	wire logic rtc_sup_s = sync_b[0];

	// Reset pin low filter
	logic [1:0] pin_low_cnt;
	logic pin_ok;
	wire logic pin_low_hit = !pin_s && (pin_low_cnt == CRC_PIN_LOW_LAST);
	wire logic [1:0] next_pin_low_cnt = pin_s ? CRC_PIN_CNT_RST :
		(pin_low_hit ? pin_low_cnt : pin_low_cnt + 2'h1);
	wire logic next_pin_ok = pin_s ? 1'h1 : (pin_low_hit ? 1'h0 : pin_ok);

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pin_low_cnt <= CRC_PIN_CNT_RST;
			pin_ok <= 1'h1;
		end else begin
			pin_low_cnt <= next_pin_low_cnt;
			pin_ok <= next_pin_ok;
		end
	end

	// Supply qualification timers run only while monitoring is active
	logic bandgap_done;
	logic analog_done;

	crc_qual_timer #(
		.CYCLES(BANDGAP_CYC)
	) u_bandgap_tmr (
		.clock(clock),
		.rst_b(rst_b),
		.level(sup_s.bandgap_on && !reg_disabled),
		.done(bandgap_done)
	);

	crc_qual_timer #(
		.CYCLES(ANALOG_CYC)
	) u_analog_tmr (
		.clock(clock),
		.rst_b(rst_b),
		.level(sup_s.analog_on && !reg_disabled),
		.done(analog_done)
	);

	// Hysteresis lives in the analog comparator; threshold_low picks its level
	wire logic all_ok = sup_s.reg_input_ok && bandgap_done && analog_done && sup_s.output_above;
	wire logic next_power_ok = reg_disabled || all_ok;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			power_ok_signal <= 1'h0;
			comparator_enable <= 1'h0;
			threshold_low <= 1'h0;
		end else begin
			power_ok_signal <= next_power_ok;
			comparator_enable <= !reg_disabled;
			threshold_low <= next_power_ok && !reg_disabled;
		end
	end

	// Combined reset: asserts at once, releases after two clock edges
	wire logic comb_n = rst_b && pin_ok && power_ok_signal;
	logic rel_a;

	always_ff @(posedge clock or negedge comb_n) begin
		if (!comb_n) begin
			rel_a <= 1'h0;
			global_reset_n <= 1'h0;
		end else begin
			rel_a <= 1'h1;
			global_reset_n <= rel_a;
		end
	end

	// Boot sequencer
	crc_state_t state;
	crc_state_t next_state;
	wire logic in_reset = !global_reset_n;

	always_comb begin
		next_state = state;
		unique case (state)
			CRC_ST_HOLD: begin
				if (global_reset_n) begin
					next_state = CRC_ST_BOOT;
				end
			end
			CRC_ST_BOOT: begin
				next_state = in_reset ? CRC_ST_HOLD : CRC_ST_RUN;
			end
			CRC_ST_RUN: begin
				if (in_reset) begin
					next_state = CRC_ST_HOLD;
				end
			end
			default: begin
				next_state = CRC_ST_HOLD;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state <= CRC_ST_HOLD;
			boot_start <= 1'h0;
		end else begin
			state <= next_state;
			boot_start <= (state == CRC_ST_HOLD) && global_reset_n;
		end
	end

	// Clock generator is forced on whenever hardware reset is applied
	wire logic next_clk_gen = in_reset ? 1'h1 : (clk_gen_off_req ? 1'h0 : clock_gen_enable);

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			clock_gen_enable <= 1'h1;
		end else begin
			clock_gen_enable <= next_clk_gen;
		end
	end

	// Software resets stay separate from the hardware reset output
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cpu_reset_n <= 1'h0;
			periph_reset_n <= CRC_PERIPH_RST;
		end else begin
			cpu_reset_n <= global_reset_n && !cpu_reset_req;
			periph_reset_n <= {CRC_PERIPH_N{global_reset_n}} & ~periph_reset_req;
		end
	end

	// Pin groups and multiplexing
	wire crc_pin_ctl_t next_pin_ctl = in_reset ? CRC_PIN_CTL_RST :
		crc_pin_ctl_t'{forced: 1'h0, high_grp: 1'h1, low_grp: 1'h0, z_grp_oe: 1'h1,
		clock_output_pin_en: 1'h1, synch_grp: 1'h1};
	wire logic [CRC_BUS_SEL_W-1:0] next_mux_sel = in_reset ? CRC_BUS_SEL_RST :
		external_bus_select_reg;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pin_ctl <= CRC_PIN_CTL_RST;
			pin_mux_sel <= CRC_BUS_SEL_RST;
		end else begin
			pin_ctl <= next_pin_ctl;
			pin_mux_sel <= next_mux_sel;
		end
	end

	// RTC power-on reset; never touched by the global reset
	logic rtc_sup_prev;
	wire logic rtc_por = rtc_sup_s && !rtc_sup_prev;
	wire logic next_loss_flag = rtc_por || (rtc_power_loss_flag && !rtc_time_written);

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rtc_sup_prev <= 1'h0;
			rtc_reg_reset_n <= 1'h0;
			rtc_power_loss_flag <= 1'h1;
		end else begin
			rtc_sup_prev <= rtc_sup_s;
			rtc_reg_reset_n <= !rtc_por;
			rtc_power_loss_flag <= next_loss_flag;
		end
	end

	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	a_pin_holds_reset: assert property (!pin_ok |=> !global_reset_n)
		else $error("Filtered reset pin low did not hold global reset");
	a_power_holds_reset: assert property (!power_ok_signal |=> !global_reset_n)
		else $error("Power-ok low did not hold global reset");
	a_disabled_forces_ok: assert property (reg_disabled |=> power_ok_signal && !comparator_enable)
		else $error("Disabled regulator did not force power-ok high");
	a_ok_needs_all: assert property (!reg_disabled && !all_ok |=> !power_ok_signal)
		else $error("Power-ok rose without all supply conditions");
	a_thresh_after_ok: assert property (power_ok_signal && comparator_enable
		|-> threshold_low)
		else $error("Threshold not lowered while power-ok high");
	a_rtc_flag_stable: assert property (!rtc_por && !rtc_time_written
		|=> $stable(rtc_power_loss_flag))
		else $error("RTC power-loss flag moved without its own causes");
	a_boot_on_release: assert property ($rose(global_reset_n) |=> boot_start ##1 !boot_start)
		else $error("Boot start pulse missing after reset release");
	a_clkgen_in_reset: assert property (!global_reset_n |=> clock_gen_enable)
		else $error("Clock generator off during reset");
	a_rtc_por_pulse: assert property (rtc_por |=> !rtc_reg_reset_n ##1 rtc_reg_reset_n)
		else $error("RTC register reset not a one-cycle pulse");
	a_rtc_flag_set: assert property (rtc_por |=> rtc_power_loss_flag)
		else $error("RTC power-on reset did not set power-loss flag");
	a_pins_forced: assert property (!global_reset_n |=> pin_ctl.forced && !pin_ctl.synch_grp
		&& !pin_ctl.z_grp_oe && pin_ctl.high_grp && !pin_ctl.low_grp)
		else $error("Pin groups not in reset state");
	a_mux_follows_sel: assert property (global_reset_n
		|=> pin_mux_sel == $past(external_bus_select_reg))
		else $error("Pin mux ignored the bus selection");
	a_cpu_reset_sep: assert property (cpu_reset_req |=> !cpu_reset_n)
		else $error("CPU software reset not applied");
	a_short_low_ignored: assert property (pin_ok && !pin_s ##1 pin_s |=> pin_ok)
		else $error("Short reset pin pulse was recognised");
	a_long_low_taken: assert property (!pin_s [*3] |=> !pin_ok)
		else $error("Three-cycle reset pin low not recognised");
	a_release_two_stage: assert property ($rose(global_reset_n)
		|-> $past(comb_n, 1) && $past(comb_n, 2))
		else $error("Global reset released without two synchroniser stages");

	// Opposite directions of the same rules, so a stuck output cannot pass
	a_ok_when_ready: assert property (!reg_disabled && all_ok |=> power_ok_signal)
		else $error("Power-ok stayed low with all supply conditions met");
	a_assert_at_once: assert property (!comb_n |-> !global_reset_n)
		else $error("Global reset lagged its combined cause");
	a_boot_only_release: assert property (boot_start |-> $past(global_reset_n)
		&& !$past(global_reset_n, 2))
		else $error("Boot start without a fresh reset release");
	a_clkgen_off_run: assert property (global_reset_n && clk_gen_off_req
		|=> !clock_gen_enable)
		else $error("Clock generator stop request ignored outside reset");
	a_soft_in_reset: assert property (!global_reset_n |=> !cpu_reset_n
		&& periph_reset_n == CRC_PERIPH_RST)
		else $error("Software reset outputs released during hardware reset");
	a_mux_cleared: assert property (!global_reset_n |=> pin_mux_sel == CRC_BUS_SEL_RST)
		else $error("Pin mux followed the selection during reset");
	a_loss_flag_clear: assert property (!rtc_por && rtc_time_written
		|=> !rtc_power_loss_flag)
		else $error("RTC power-loss flag not cleared by software");

	c_power_up: cover property ($rose(power_ok_signal) ##[1:4] $rose(global_reset_n));
	c_pin_reset: cover property (global_reset_n ##1 !pin_ok ##[1:8] $rose(global_reset_n));
	c_rtc_por: cover property (rtc_por ##[1:20] rtc_time_written);
	c_sw_reset: cover property (global_reset_n && periph_reset_req[0] && !cpu_reset_req);
	c_regulator_off: cover property ($rose(reg_disabled) ##[1:4] $rose(global_reset_n));

endmodule : crc_reset_combiner

// ---- bench/crc_supervisor.sv ----
// Board reset supervisor model that drives the external reset pin
`timescale 1ns/1ns
module crc_supervisor (
	input wire logic clock, // System clock
	input wire logic req, // Board asks for a reset
	input wire logic short_ok, // Lets a too-short pulse through
	output logic reset_pin_n // External reset pin, active low
);
	logic [1:0] low_cnt = 2'h0;
	// Pin is released from the first edge; an unknown level counts as released
	// Every pulse is stretched to three clock periods unless told otherwise
	always @(posedge clock) begin
		if (req) begin
			reset_pin_n <= 1'b0;
			low_cnt <= low_cnt + 2'(low_cnt != 2'h3);
		end else if (short_ok || low_cnt == 2'h3 || reset_pin_n !== 1'b0) begin
			reset_pin_n <= 1'b1;
			low_cnt <= 2'h0;
		end else begin
			low_cnt <= low_cnt + 2'h1;
		end
	end
endmodule : crc_supervisor

// ---- bench/crc_reset_combiner_bench.sv ----
// Self-checking bench for the chip reset combiner
`timescale 1ns/1ns
module crc_reset_combiner_bench;
	import crc_pkg::*;
	logic clock, rst_b, sup_req, short_ok, reset_pin_n, core_regulator_enable_n;
	crc_supply_t supply;
	logic rtc_core_supply, rtc_time_written, clk_gen_off_req, cpu_reset_req;
	logic [CRC_PERIPH_N-1:0] periph_reset_req, periph_reset_n;
	logic [CRC_BUS_SEL_W-1:0] external_bus_select_reg, pin_mux_sel;
	logic global_reset_n, power_ok_signal, comparator_enable, threshold_low, boot_start;
	logic clock_gen_enable, cpu_reset_n, rtc_reg_reset_n, rtc_power_loss_flag;
	crc_pin_ctl_t pin_ctl;
	int errors = 0;
	int compares = 0;

	crc_supervisor sup (.clock(clock), .req(sup_req), .short_ok(short_ok),
		.reset_pin_n(reset_pin_n));
	crc_reset_combiner #(.BANDGAP_CYC(20), .ANALOG_CYC(10)) dut (.clock(clock), .rst_b(rst_b),
		.reset_pin_n(reset_pin_n), .core_regulator_enable_n(core_regulator_enable_n),
		.supply(supply), .rtc_core_supply(rtc_core_supply), .rtc_time_written(rtc_time_written),
		.clk_gen_off_req(clk_gen_off_req), .cpu_reset_req(cpu_reset_req),
		.periph_reset_req(periph_reset_req), .external_bus_select_reg(external_bus_select_reg),
		.global_reset_n(global_reset_n), .power_ok_signal(power_ok_signal),
		.comparator_enable(comparator_enable), .threshold_low(threshold_low),
		.boot_start(boot_start), .clock_gen_enable(clock_gen_enable), .cpu_reset_n(cpu_reset_n),
		.periph_reset_n(periph_reset_n), .rtc_reg_reset_n(rtc_reg_reset_n),
		.rtc_power_loss_flag(rtc_power_loss_flag), .pin_ctl(pin_ctl), .pin_mux_sel(pin_mux_sel));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(negedge clock);
	endtask : step

	task automatic wait_grn(input logic v, input int lim);
		for (int n = 0; n < lim && global_reset_n !== v; n++) step(1);
	endtask : wait_grn

	task automatic end_sim;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_sim

	task automatic t_power_up;
		@(posedge clock);
		rst_b <= 1'b1;
		step(15);
		chk("power_ok early", 1'b0, power_ok_signal);
		chk("comparator_enable", 1'b1, comparator_enable);
		for (int n = 0; n < 30 && power_ok_signal !== 1'b1; n++) step(1);
		chk("power_ok", 1'b1, power_ok_signal);
		wait_grn(1'b1, 6);
		chk("global_reset_n", 1'b1, global_reset_n);
		step(1);
		chk("boot_start", 1'b1, boot_start);
		chk("threshold_low", 1'b1, threshold_low);
		step(1);
		chk("boot_start end", 1'b0, boot_start);
		chk("pin_ctl run", 16'h0017, 16'(pin_ctl));
		chk("pin_mux_sel", external_bus_select_reg, pin_mux_sel);
		$display("t_power_up done");
	endtask : t_power_up

	task automatic t_supply_drop;
		@(posedge clock);
		supply.output_above <= 1'b0;
		for (int n = 0; n < 8 && power_ok_signal !== 1'b0; n++) step(1);
		chk("power_ok drop", 1'b0, power_ok_signal);
		wait_grn(1'b0, 3);
		chk("global_reset_n drop", 1'b0, global_reset_n);
		step(2);
		chk("pin_ctl reset", 16'(CRC_PIN_CTL_RST), 16'(pin_ctl));
		chk("pin_mux_sel reset", 16'h0000, pin_mux_sel);
		@(posedge clock);
		supply.output_above <= 1'b1;
		wait_grn(1'b1, 40);
		chk("global_reset_n back", 1'b1, global_reset_n);
		$display("t_supply_drop done");
	endtask : t_supply_drop

	task automatic t_soft;
		@(posedge clock);
		cpu_reset_req <= 1'b1;
		periph_reset_req <= 8'h5a;
		step(2);
		chk("cpu_reset_n", 1'b0, cpu_reset_n);
		chk("periph_reset_n", 16'h00a5, periph_reset_n);
		chk("global_reset_n soft", 1'b1, global_reset_n);
		@(posedge clock);
		cpu_reset_req <= 1'b0;
		periph_reset_req <= 8'h00;
		step(2);
		chk("cpu_reset_n off", 1'b1, cpu_reset_n);
		chk("periph_reset_n off", 16'h00ff, periph_reset_n);
		$display("t_soft done");
	endtask : t_soft

	task automatic t_rtc;
		@(posedge clock);
		rtc_time_written <= 1'b1;
		@(posedge clock);
		rtc_time_written <= 1'b0;
		step(2);
		chk("rtc flag cleared", 1'b0, rtc_power_loss_flag);
		@(posedge clock);
		rtc_core_supply <= 1'b1;
		for (int n = 0; n < 6 && rtc_reg_reset_n !== 1'b0; n++) step(1);
		chk("rtc_reg_reset_n", 1'b0, rtc_reg_reset_n);
		step(1);
		chk("rtc_reg_reset_n end", 1'b1, rtc_reg_reset_n);
		step(1);
		chk("rtc flag set", 1'b1, rtc_power_loss_flag);
		@(posedge clock);
		rtc_time_written <= 1'b1;
		@(posedge clock);
		rtc_time_written <= 1'b0;
		step(2);
		$display("t_rtc done");
	endtask : t_rtc

	task automatic t_pin_filter;
		logic seen_low;
		seen_low = 1'b0;
		@(posedge clock);
		clk_gen_off_req <= 1'b1;
		short_ok <= 1'b1;
		sup_req <= 1'b1;
		@(posedge clock);
		clk_gen_off_req <= 1'b0;
		@(posedge clock);
		sup_req <= 1'b0;
		chk("clock_gen off", 1'b0, clock_gen_enable);
		for (int n = 0; n < 10; n++) begin
			step(1);
			if (global_reset_n !== 1'b1) seen_low = 1'b1;
		end
		chk("short pulse ignored", 1'b0, seen_low);
		@(posedge clock);
		short_ok <= 1'b0;
		sup_req <= 1'b1;
		@(posedge clock);
		sup_req <= 1'b0;
		wait_grn(1'b0, 10);
		chk("pin reset", 1'b0, global_reset_n);
		step(1);
		chk("clock_gen in reset", 1'b1, clock_gen_enable);
		chk("rtc flag kept", 1'b0, rtc_power_loss_flag);
		wait_grn(1'b1, 10);
		step(1);
		chk("boot after pin", 1'b1, boot_start);
		$display("t_pin_filter done");
	endtask : t_pin_filter

	task automatic t_regoff;
		@(posedge clock);
		supply.bandgap_on <= 1'b0;
		wait_grn(1'b0, 10);
		chk("bandgap loss", 1'b0, power_ok_signal);
		@(posedge clock);
		core_regulator_enable_n <= 1'b1;
		for (int n = 0; n < 5 && power_ok_signal !== 1'b1; n++) step(1);
		chk("power_ok forced", 1'b1, power_ok_signal);
		step(1);
		chk("monitor off", 1'b0, comparator_enable);
		wait_grn(1'b1, 5);
		chk("pin sole source", 1'b1, global_reset_n);
		@(posedge clock);
		sup_req <= 1'b1;
		@(posedge clock);
		sup_req <= 1'b0;
		wait_grn(1'b0, 10);
		chk("pin reset unregulated", 1'b0, global_reset_n);
		$display("t_regoff done");
	endtask : t_regoff

	initial begin
		rst_b = 1'b0;
		sup_req = 1'b0;
		short_ok = 1'b0;
		core_regulator_enable_n = 1'b0;
		supply = '{reg_input_ok: 1'b1, bandgap_on: 1'b1, analog_on: 1'b1, output_above: 1'b1};
		rtc_core_supply = 1'b0;
		rtc_time_written = 1'b0;
		clk_gen_off_req = 1'b0;
		cpu_reset_req = 1'b0;
		periph_reset_req = 8'h00;
		external_bus_select_reg = 16'ha5c3;
		step(16);
		chk("grn in reset", 1'b0, global_reset_n);
		chk("clock_gen reset", 1'b1, clock_gen_enable);
		chk("rtc flag reset", 1'b1, rtc_power_loss_flag);
		chk("pin_ctl reset", 16'(CRC_PIN_CTL_RST), 16'(pin_ctl));
		t_power_up();
		t_supply_drop();
		t_soft();
		t_rtc();
		t_pin_filter();
		t_regoff();
		end_sim();
	end

	initial begin
		#60000;
		errors++;
		end_sim();
	end
endmodule : crc_reset_combiner_bench
